// file: rtl/exec_alu.sv
// combinational datapath: result, carry and write targets for one instruction
module exec_alu (
	input  wire exec_pkg::op_t      op,
	input  wire logic [7:0]         acc,
	input  wire logic [7:0]         mem,
	input  wire logic [7:0]         imm,
	input  wire exec_pkg::flags_t   flags,
	output exec_pkg::alu_out_t      alu_o
);

	logic [7:0] corr;
	logic       hi_adj;
	logic [8:0] sum9;

	always_comb begin
		hi_adj = (acc[7:4] > exec_pkg::NIBBLE_MAX) || flags.carry_flag;
		corr = exec_pkg::ADJ_NONE;
		if ((acc[3:0] > exec_pkg::NIBBLE_MAX) || flags.half_carry_flag) begin
			corr = corr | exec_pkg::ADJ_LOW;
		end
		if (hi_adj) begin
			corr = corr | exec_pkg::ADJ_HIGH;
		end
		sum9 = {1'b0, acc} + {1'b0, corr};
		alu_o = '0;
		alu_o.carry = flags.carry_flag;
		case (op)
			exec_pkg::op_complement_mem: begin
				alu_o.result = ~mem;
				alu_o.wr_mem = 1'b1;
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_complement_to_acc: begin
				alu_o.result = ~mem;
				alu_o.wr_acc = 1'b1;
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_decimal_adjust: begin
				alu_o.result = sum9[7:0];
				alu_o.wr_mem = 1'b1;
				alu_o.upd_carry = 1'b1;
				alu_o.carry = hi_adj | sum9[8];
			end
			exec_pkg::op_decrement_mem, exec_pkg::op_decrement_to_acc: begin
				alu_o.result = mem - exec_pkg::ONE;
				alu_o.wr_mem = (op == exec_pkg::op_decrement_mem);
				alu_o.wr_acc = (op == exec_pkg::op_decrement_to_acc);
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_increment_mem, exec_pkg::op_increment_to_acc: begin
				alu_o.result = mem + exec_pkg::ONE;
				alu_o.wr_mem = (op == exec_pkg::op_increment_mem);
				alu_o.wr_acc = (op == exec_pkg::op_increment_to_acc);
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_move_mem_to_acc: begin
				alu_o.result = mem;
				alu_o.wr_acc = 1'b1;
			end
			exec_pkg::op_move_imm_to_acc, exec_pkg::op_return_load_imm: begin
				alu_o.result = imm;
				alu_o.wr_acc = 1'b1;
			end
			exec_pkg::op_move_acc_to_mem: begin
				alu_o.result = acc;
				alu_o.wr_mem = 1'b1;
			end
			exec_pkg::op_or_mem_to_acc, exec_pkg::op_or_to_mem: begin
				alu_o.result = acc | mem;
				alu_o.wr_acc = (op == exec_pkg::op_or_mem_to_acc);
				alu_o.wr_mem = (op == exec_pkg::op_or_to_mem);
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_or_imm_to_acc: begin
				alu_o.result = acc | imm;
				alu_o.wr_acc = 1'b1;
				alu_o.upd_zero = 1'b1;
			end
			exec_pkg::op_rotate_left, exec_pkg::op_rotate_left_to_acc: begin
				alu_o.result = {mem[6:0], mem[7]};
				alu_o.wr_mem = (op == exec_pkg::op_rotate_left);
				alu_o.wr_acc = (op == exec_pkg::op_rotate_left_to_acc);
			end
			exec_pkg::op_rotate_left_carry, exec_pkg::op_rotate_left_carry_to_acc: begin
				alu_o.result = {mem[6:0], flags.carry_flag};
				alu_o.carry = mem[7];
				alu_o.upd_carry = 1'b1;
				alu_o.wr_mem = (op == exec_pkg::op_rotate_left_carry);
				alu_o.wr_acc = (op == exec_pkg::op_rotate_left_carry_to_acc);
			end
			exec_pkg::op_rotate_right, exec_pkg::op_rotate_right_to_acc: begin
				alu_o.result = {mem[0], mem[7:1]};
				alu_o.wr_mem = (op == exec_pkg::op_rotate_right);
				alu_o.wr_acc = (op == exec_pkg::op_rotate_right_to_acc);
			end
			exec_pkg::op_rotate_right_carry, exec_pkg::op_rotate_right_carry_to_acc: begin
				alu_o.result = {flags.carry_flag, mem[7:1]};
				alu_o.carry = mem[0];
				alu_o.upd_carry = 1'b1;
				alu_o.wr_mem = (op == exec_pkg::op_rotate_right_carry);
				alu_o.wr_acc = (op == exec_pkg::op_rotate_right_carry_to_acc);
			end
			default: begin
				alu_o.result = 8'h00;
			end
		endcase
	end

endmodule

// file: rtl/exec_pkg.sv
// package: shared constants, opcode set and carrier structs of the execute block
// Contract
// - pre-clears act only when alternated.
// - effective pre-clear clears counter, timeout, powerdown flags.
// - flags cleared only after back-to-back pair.
// - complement to memory or accumulator, zero updated.
// - accumulator complement leaves memory untouched.
// - decimal adjust adds 06H, 60H or 66H.
// - decimal adjust changes only the carry.
// - decrement to memory or accumulator, zero updated.
// - increment to memory or accumulator, zero updated.
// - halt stops execution and clock, keeps contents.
// - halt clears counter, prescaler, timeout; sets powerdown.
// - jump loads target, two cycles, no flags.
// - moves change no flag.
// - no-operation alters no state; the code still clears the pre-clear pairing memory (last_a, last_b).
// - OR updates only the zero flag.
// - return pops counter, flags untouched.
// - immediate return also loads the accumulator.
// - interrupt return sets global interrupt enable.
// - pending interrupt serviced first after interrupt return.
// - rotate left, bit 7 into bit 0.
// - rotate left through carry.
// - rotate right, bit 0 into bit 7.
// - rotate right through carry to memory.
// - counter-changing instructions take two cycles.
package exec_pkg;

	// ----------------------------------------------------------------
	// register port map
	// ----------------------------------------------------------------
	localparam int          REG_ADDR_W   = 8;
	localparam logic [7:0]  REG_STATUS   = 8'h00;
	localparam logic [7:0]  REG_ACC      = 8'h04;
	localparam logic [7:0]  REG_CTRL     = 8'h08;
	localparam int          FLAG_Z       = 0;
	localparam int          FLAG_C       = 1;
	localparam int          FLAG_HC      = 2;
	localparam int          FLAG_TO      = 3;
	localparam int          FLAG_PD      = 4;
	localparam int          CTRL_IRQ_EN  = 0;

	// ----------------------------------------------------------------
	// reset values and arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [3:0]  NIBBLE_MAX   = 4'h9;
	localparam logic [7:0]  ADJ_LOW      = 8'h06;
	localparam logic [7:0]  ADJ_HIGH     = 8'h60;
	localparam logic [7:0]  ADJ_NONE     = 8'h00;
	localparam logic [7:0]  ONE          = 8'h01;
	localparam int          BRANCH_CYCLES = 2;

	typedef enum logic [4:0] {
		op_nop                   = 5'h00,
		op_watchdog_preclear_a   = 5'h01,
		op_watchdog_preclear_b   = 5'h02,
		op_complement_mem        = 5'h03,
		op_complement_to_acc     = 5'h04,
		op_decimal_adjust        = 5'h05,
		op_decrement_mem         = 5'h06,
		op_decrement_to_acc      = 5'h07,
		op_increment_mem         = 5'h08,
		op_increment_to_acc      = 5'h09,
		op_power_down            = 5'h0A,
		op_jump                  = 5'h0B,
		op_move_mem_to_acc       = 5'h0C,
		op_move_imm_to_acc       = 5'h0D,
		op_move_acc_to_mem       = 5'h0E,
		op_or_mem_to_acc         = 5'h0F,
		op_or_imm_to_acc         = 5'h10,
		op_or_to_mem             = 5'h11,
		op_return                = 5'h12,
		op_return_load_imm       = 5'h13,
		op_return_from_irq       = 5'h14,
		op_rotate_left           = 5'h15,
		op_rotate_left_to_acc    = 5'h16,
		op_rotate_left_carry     = 5'h17,
		op_rotate_left_carry_to_acc  = 5'h18,
		op_rotate_right          = 5'h19,
		op_rotate_right_to_acc   = 5'h1A,
		op_rotate_right_carry    = 5'h1B,
		op_rotate_right_carry_to_acc = 5'h1C
	} op_t;

	typedef struct packed {
		logic powerdown_flag;
		logic timeout_flag;
		logic half_carry_flag;
		logic carry_flag;
		logic zero_flag;
	} flags_t;

	typedef struct packed {
		logic [7:0] result;
		logic       carry;
		logic       wr_acc;
		logic       wr_mem;
		logic       upd_zero;
		logic       upd_carry;
	} alu_out_t;

endpackage

// file: rtl/instr_exec.sv
// execute stage: accumulator, flags, program counter, watchdog pairing and halt
module instr_exec #(
	parameter int PC_W = 12
) (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire logic                            op_valid,
	output logic                                 op_ready,
	input  wire exec_pkg::op_t                   op,
	input  wire logic [7:0]                      mem_rdata,
	input  wire logic [7:0]                      mem_addr,
	input  wire logic [7:0]                      imm,
	input  wire logic [PC_W-1:0]                 jump_addr,
	input  wire logic [PC_W-1:0]                 stack_rdata,
	output logic                                 stack_pop,
	input  wire logic                            irq_pending,
	input  wire logic                            wake,
	output logic                                 mem_we,
	output logic [7:0]                           mem_waddr,
	output logic [7:0]                           mem_wdata,
	output logic [PC_W-1:0]                      pc,
	output logic [7:0]                           acc,
	output exec_pkg::flags_t                     flags,
	output logic                                 global_irq_enable,
	output logic                                 irq_service,
	output logic                                 watchdog_clear,
	output logic                                 prescaler_clear,
	output logic                                 clock_stop,
	input  wire logic [exec_pkg::REG_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                      reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic [7:0]                           reg_rdata
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		st_run   = 3'b001,
		st_dummy = 3'b010,
		st_halt  = 3'b100
	} state_t;

	typedef struct packed {
		state_t           st;
		logic [PC_W-1:0]  pc;
		logic [7:0]       acc;
		exec_pkg::flags_t flags;
		logic             irq_en;
		logic             last_a;
		logic             last_b;
		logic             mem_we;
		logic [7:0]       mem_waddr;
		logic [7:0]       mem_wdata;
		logic             wd_clear;
		logic             ps_clear;
		logic             irq_service;
		logic [7:0]       rdata;
	} exec_state_t;

	exec_state_t        s_r;
	exec_state_t        s_nxt;
	exec_pkg::alu_out_t alu_o;
	logic               accept;
	logic               is_return;

	exec_alu u_alu (
		.op    (op),
		.acc   (s_r.acc),
		.mem   (mem_rdata),
		.imm   (imm),
		.flags (s_r.flags),
		.alu_o (alu_o)
	);

	assign op_ready  = (s_r.st == st_run);
	assign accept    = op_valid && op_ready;
	assign is_return = (op == exec_pkg::op_return) || (op == exec_pkg::op_return_load_imm)
		|| (op == exec_pkg::op_return_from_irq);
	assign stack_pop = accept && is_return;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.mem_we = 1'b0;
		s_nxt.wd_clear = 1'b0;
		s_nxt.ps_clear = 1'b0;
		s_nxt.irq_service = 1'b0;
		s_nxt.rdata = 8'h00;
		// software access first so that instruction updates win the same cycle
		if (reg_wr) begin
			case (reg_addr)
				exec_pkg::REG_STATUS: begin
					s_nxt.flags.zero_flag = reg_wdata[exec_pkg::FLAG_Z];
					s_nxt.flags.carry_flag = reg_wdata[exec_pkg::FLAG_C];
					s_nxt.flags.half_carry_flag = reg_wdata[exec_pkg::FLAG_HC];
				end
				exec_pkg::REG_ACC: begin
					s_nxt.acc = reg_wdata;
				end
				exec_pkg::REG_CTRL: begin
					s_nxt.irq_en = reg_wdata[exec_pkg::CTRL_IRQ_EN];
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				exec_pkg::REG_STATUS: s_nxt.rdata = {3'h0, s_r.flags};
				exec_pkg::REG_ACC: s_nxt.rdata = s_r.acc;
				exec_pkg::REG_CTRL: s_nxt.rdata = {7'h00, s_r.irq_en};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		case (s_r.st)
			st_run: begin
				if (op_valid) begin
					s_nxt.pc = s_r.pc + {{(PC_W-1){1'b0}}, 1'b1};
					if (alu_o.wr_acc) begin
						s_nxt.acc = alu_o.result;
					end
					if (alu_o.wr_mem) begin
						s_nxt.mem_we = 1'b1;
						s_nxt.mem_waddr = mem_addr;
						s_nxt.mem_wdata = alu_o.result;
					end
					if (alu_o.upd_zero) begin
						s_nxt.flags.zero_flag = (alu_o.result == 8'h00);
					end
					if (alu_o.upd_carry) begin
						s_nxt.flags.carry_flag = alu_o.carry;
					end
					// pairing memory forgets on any other instruction
					s_nxt.last_a = 1'b0;
					s_nxt.last_b = 1'b0;
					case (op)
						exec_pkg::op_watchdog_preclear_a: begin
							if (s_r.last_b) begin
								s_nxt.wd_clear = 1'b1;
								s_nxt.flags.timeout_flag = 1'b0;
								s_nxt.flags.powerdown_flag = 1'b0;
							end else begin
								s_nxt.last_a = 1'b1;
							end
						end
						exec_pkg::op_watchdog_preclear_b: begin
							if (s_r.last_a) begin
								s_nxt.wd_clear = 1'b1;
								s_nxt.flags.timeout_flag = 1'b0;
								s_nxt.flags.powerdown_flag = 1'b0;
							end else begin
								s_nxt.last_b = 1'b1;
							end
						end
						exec_pkg::op_power_down: begin
							s_nxt.wd_clear = 1'b1;
							s_nxt.ps_clear = 1'b1;
							s_nxt.flags.timeout_flag = 1'b0;
							s_nxt.flags.powerdown_flag = 1'b1;
							s_nxt.st = st_halt;
						end
						exec_pkg::op_jump: begin
							s_nxt.pc = jump_addr;
							s_nxt.st = st_dummy;
						end
						exec_pkg::op_return, exec_pkg::op_return_load_imm: begin
							s_nxt.pc = stack_rdata;
							s_nxt.st = st_dummy;
						end
						exec_pkg::op_return_from_irq: begin
							s_nxt.pc = stack_rdata;
							s_nxt.irq_en = 1'b1;
							s_nxt.irq_service = irq_pending;
							s_nxt.st = st_dummy;
						end
						default: begin
							s_nxt.st = st_run;
						end
					endcase
				end
			end
			st_dummy: begin
				s_nxt.st = st_run;
			end
			st_halt: begin
				if (wake) begin
					s_nxt.st = st_run;
				end
			end
			default: begin
				s_nxt.st = st_run;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_r <= '{st: st_run, pc: '0, acc: exec_pkg::ACC_RST, flags: '0, irq_en: 1'b0,
				last_a: 1'b0, last_b: 1'b0, mem_we: 1'b0, mem_waddr: 8'h00,
				mem_wdata: 8'h00, wd_clear: 1'b0, ps_clear: 1'b0, irq_service: 1'b0,
				rdata: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign mem_we            = s_r.mem_we;
	assign mem_waddr         = s_r.mem_waddr;
	assign mem_wdata         = s_r.mem_wdata;
	assign pc                = s_r.pc;
	assign acc               = s_r.acc;
	assign flags             = s_r.flags;
	assign global_irq_enable = s_r.irq_en;
	assign irq_service       = s_r.irq_service;
	assign watchdog_clear    = s_r.wd_clear;
	assign prescaler_clear   = s_r.ps_clear;
	assign clock_stop        = (s_r.st == st_halt);
	assign reg_rdata         = s_r.rdata;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	preclear_single_a: assert property (
		accept && op == exec_pkg::op_watchdog_preclear_a && !s_r.last_b
		|=> !watchdog_clear && $stable(flags.timeout_flag) && $stable(flags.powerdown_flag))
		else $error("lone pre-clear had an effect");

	preclear_pair_a: assert property (
		accept && op == exec_pkg::op_watchdog_preclear_b && s_r.last_a
		|=> watchdog_clear && !flags.timeout_flag && !flags.powerdown_flag)
		else $error("pre-clear pair did not clear");

	// last accepted instruction, tracked apart from the pairing logic it checks
	exec_pkg::op_t prev_op_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			prev_op_r <= exec_pkg::op_nop;
		end else if (accept) begin
			prev_op_r <= op;
		end
	end

	preclear_gap_a: assert property (
		accept && ((op == exec_pkg::op_watchdog_preclear_a
		&& prev_op_r != exec_pkg::op_watchdog_preclear_b)
		|| (op == exec_pkg::op_watchdog_preclear_b
		&& prev_op_r != exec_pkg::op_watchdog_preclear_a))
		|=> !watchdog_clear && $stable(flags.timeout_flag) && $stable(flags.powerdown_flag))
		else $error("separated pre-clears took effect");

	halt_flags_a: assert property (
		accept && op == exec_pkg::op_power_down
		|=> flags.powerdown_flag && !flags.timeout_flag && watchdog_clear
		&& prescaler_clear && clock_stop)
		else $error("halt flags wrong");

	halt_hold_a: assert property (
		clock_stop && !wake && !reg_wr
		|=> clock_stop && $stable(acc) && $stable(pc) && !op_ready)
		else $error("halted core changed state");

	jump_two_a: assert property (
		accept && op == exec_pkg::op_jump
		|=> pc == $past(jump_addr) && !op_ready && $stable(flags) ##1 op_ready)
		else $error("jump timing wrong");

	return_pc_a: assert property (
		accept && is_return |-> stack_pop ##1 (pc == $past(stack_rdata) && !op_ready))
		else $error("return did not pop");

	return_from_irq_irq_a: assert property (
		accept && op == exec_pkg::op_return_from_irq
		|=> global_irq_enable && (irq_service == $past(irq_pending)))
		else $error("interrupt return handling wrong");

	cpl_acc_a: assert property (
		accept && op == exec_pkg::op_complement_to_acc && !reg_wr
		|=> !mem_we && acc == ~$past(mem_rdata) && flags.zero_flag == (acc == 8'h00))
		else $error("accumulator complement wrong");

	daa_flags_a: assert property (
		accept && op == exec_pkg::op_decimal_adjust && !reg_wr
		|=> mem_we && $stable(flags.zero_flag) && $stable(flags.half_carry_flag) && $stable(acc))
		else $error("decimal adjust touched other state");

	zero_flag_a: assert property (
		accept && alu_o.upd_zero |=> flags.zero_flag == ($past(alu_o.result) == 8'h00))
		else $error("zero flag wrong");

	rotate_left_a: assert property (
		accept && op == exec_pkg::op_rotate_left && !reg_wr
		|=> mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
		&& $stable(flags))
		else $error("rotate left wrong");

	rotate_rc_a: assert property (
		accept && op == exec_pkg::op_rotate_right_carry
		|=> mem_we && flags.carry_flag == $past(mem_rdata[0])
		&& mem_wdata[7] == $past(s_r.flags.carry_flag))
		else $error("rotate right through carry wrong");

	nop_state_a: assert property (
		accept && op == exec_pkg::op_nop && !reg_wr
		|=> $stable(acc) && $stable(flags) && !mem_we && op_ready)
		else $error("no-operation changed state");

	pair_cover: cover property (accept && op == exec_pkg::op_watchdog_preclear_a
		##[1:4] accept && op == exec_pkg::op_watchdog_preclear_b);
	halt_wake_cover: cover property (clock_stop ##1 wake ##1 op_ready);
	return_from_irq_irq_cover: cover property (accept && op == exec_pkg::op_return_from_irq && irq_pending);

endmodule

// file: tb/exec_far_side.sv
// far-side model: data memory byte array and return stack feeding the execute stage
module exec_far_side #(
	parameter int PC_W = 12
) (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic [7:0]      mem_addr,
	output logic [7:0]           mem_rdata,
	input  wire logic            mem_we,
	input  wire logic [7:0]      mem_waddr,
	input  wire logic [7:0]      mem_wdata,
	output logic [PC_W-1:0]      stack_rdata,
	input  wire logic            stack_pop
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]      mem_r [256];
	logic [PC_W-1:0] stk_r [4];
	logic [1:0]      sp_r;

	// operand and stack top are offered in the same cycle as the instruction
	assign mem_rdata   = mem_r[mem_addr];
	assign stack_rdata = stk_r[sp_r];

	always @(posedge clock) begin
		if (mem_we) begin
			mem_r[mem_waddr] <= mem_wdata;
		end
		// stack comes out of reset holding three return addresses
		if (rst) begin
			sp_r     <= 2'h3;
			stk_r[3] <= PC_W'(12'h111);
			stk_r[2] <= PC_W'(12'h222);
			stk_r[1] <= PC_W'(12'h333);
			stk_r[0] <= '0;
		end else if (stack_pop) begin
			sp_r <= sp_r - 2'h1;
		end
	end
endmodule

// file: tb/testbench.sv
// self-checking bench: instruction sequences and register accesses with expected values
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic             clock, rst, op_valid, irq_pending, wake, reg_wr, reg_rd, op_ready;
	logic             stack_pop, mem_we, global_irq_enable, irq_service, watchdog_clear;
	logic             prescaler_clear, clock_stop, ready_q, svc_q, wdc_q, psc_q, stop_q;
	exec_pkg::op_t    op;
	exec_pkg::flags_t flags;
	logic [7:0]       imm, mem_addr, reg_addr, reg_wdata, mem_rdata, mem_waddr, mem_wdata;
	logic [7:0]       acc, reg_rdata, d;
	logic [11:0]      jump_addr, stack_rdata, pc;
	int               bad_count, check_count;

	instr_exec #(.PC_W(12)) u_dut (.clock, .rst, .op_valid, .op_ready, .op, .mem_rdata,
		.mem_addr, .imm, .jump_addr, .stack_rdata, .stack_pop, .irq_pending, .wake, .mem_we,
		.mem_waddr, .mem_wdata, .pc, .acc, .flags, .global_irq_enable, .irq_service,
		.watchdog_clear, .prescaler_clear, .clock_stop, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata);

	exec_far_side #(.PC_W(12)) u_far (.clock, .rst, .mem_addr, .mem_rdata, .mem_we, .mem_waddr,
		.mem_wdata, .stack_rdata, .stack_pop);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// holds the instruction until accepted, samples the one-cycle pulses after it
	task automatic exec(input exec_pkg::op_t o, input logic [7:0] x = 8'h00,
			input logic [11:0] j = 12'h000);
		int   n;
		logic hit;
		@(posedge clock);
		op_valid  <= 1'b1;
		op        <= o;
		imm       <= x;
		jump_addr <= j;
		// ready is judged settled, before the edge that takes the instruction
		for (n = 0; n < 20; n++) begin
			#1;
			hit = op_ready;
			@(posedge clock);
			if (hit === 1'b1) break;
		end
		if (n == 20) begin
			bad_count++;
			stop_test();
		end
		op_valid <= 1'b0;
		#1;
		ready_q = op_ready;
		svc_q   = irq_service;
		wdc_q   = watchdog_clear;
		psc_q   = prescaler_clear;
		stop_q  = clock_stop;
		@(posedge clock);
		#1;
	endtask

	// v = {mem, acc, imm, status}; e = {mem, acc} afterwards; f = flags afterwards
	task automatic row(input exec_pkg::op_t o, input logic [31:0] v, input logic [15:0] e,
			input logic [4:0] f);
		reg_write(exec_pkg::REG_ACC, v[31:24]);
		exec(exec_pkg::op_move_acc_to_mem);
		reg_write(exec_pkg::REG_ACC, v[23:16]);
		reg_write(exec_pkg::REG_STATUS, v[7:0]);
		exec(o, v[15:8]);
		check(mem_rdata, e[15:8]);
		check(acc, e[7:0]);
		check(flags, f);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		op_valid = 1'b0;
		op = exec_pkg::op_nop;
		imm = 8'h00;
		mem_addr = 8'h20;
		jump_addr = 12'h000;
		irq_pending = 1'b0;
		wake = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		reg_read(exec_pkg::REG_STATUS);
		check(d, 8'h00);
		reg_write(exec_pkg::REG_ACC, 8'h5A);
		reg_read(exec_pkg::REG_ACC);
		check(d, 8'h5A);
		reg_read(8'hFC);
		check(d, 8'h00);
		row(exec_pkg::op_complement_mem, 32'hFF110000, 16'h0011, 5'h01);
		row(exec_pkg::op_complement_to_acc, 32'h0F110001, 16'h0FF0, 5'h00);
		row(exec_pkg::op_decimal_adjust, 32'h773C0000, 16'h423C, 5'h00);
		row(exec_pkg::op_decimal_adjust, 32'h77A20001, 16'h02A2, 5'h03);
		row(exec_pkg::op_decimal_adjust, 32'h77120004, 16'h1812, 5'h04);
		row(exec_pkg::op_decimal_adjust, 32'h77990002, 16'hF999, 5'h02);
		row(exec_pkg::op_decimal_adjust, 32'h77AB0000, 16'h11AB, 5'h02);
		row(exec_pkg::op_decrement_mem, 32'h01000000, 16'h0000, 5'h01);
		row(exec_pkg::op_decrement_to_acc, 32'h00000001, 16'h00FF, 5'h00);
		row(exec_pkg::op_increment_mem, 32'hFF000000, 16'h0000, 5'h01);
		row(exec_pkg::op_increment_to_acc, 32'h7F000007, 16'h7F80, 5'h06);
		row(exec_pkg::op_move_mem_to_acc, 32'h00550006, 16'h0000, 5'h06);
		row(exec_pkg::op_move_imm_to_acc, 32'h1200A501, 16'h12A5, 5'h01);
		row(exec_pkg::op_move_acc_to_mem, 32'h123C0000, 16'h3C3C, 5'h00);
		row(exec_pkg::op_nop, 32'h12340005, 16'h1234, 5'h05);
		row(exec_pkg::op_or_mem_to_acc, 32'h00000006, 16'h0000, 5'h07);
		row(exec_pkg::op_or_imm_to_acc, 32'h00F00F07, 16'h00FF, 5'h06);
		row(exec_pkg::op_or_to_mem, 32'h30030001, 16'h3303, 5'h00);
		row(exec_pkg::op_rotate_left, 32'h81000001, 16'h0300, 5'h01);
		row(exec_pkg::op_rotate_left_to_acc, 32'h81000001, 16'h8103, 5'h01);
		row(exec_pkg::op_rotate_left_carry, 32'h81000001, 16'h0200, 5'h03);
		row(exec_pkg::op_rotate_left_carry_to_acc, 32'h81000001, 16'h8102, 5'h03);
		row(exec_pkg::op_rotate_right, 32'h81000001, 16'hC000, 5'h01);
		row(exec_pkg::op_rotate_right_to_acc, 32'h81000001, 16'h81C0, 5'h01);
		row(exec_pkg::op_rotate_right_carry, 32'h81000001, 16'h4000, 5'h03);
		row(exec_pkg::op_rotate_right_carry_to_acc, 32'h81000001, 16'h8140, 5'h03);
		reg_write(exec_pkg::REG_STATUS, 8'h05);
		exec(exec_pkg::op_jump, 8'h00, 12'h3A5);
		check({pc, 3'h0, ready_q}, 16'h3A50);
		check(flags, 5'h05);
		exec(exec_pkg::op_return);
		check({pc, 2'h0, u_far.sp_r}, 16'h1112);
		check({ready_q, 3'h0, flags}, 16'h0005);
		exec(exec_pkg::op_return_load_imm, 8'h9C);
		check({pc, acc[3:0]}, 16'h222C);
		check(acc, 8'h9C);
		reg_write(exec_pkg::REG_CTRL, 8'h00);
		irq_pending <= 1'b1;
		exec(exec_pkg::op_return_from_irq);
		check({pc, 2'h0, global_irq_enable, svc_q}, 16'h3333);
		@(posedge clock);
		irq_pending <= 1'b0;
		reg_read(exec_pkg::REG_CTRL);
		check(d, 8'h01);
		reg_write(exec_pkg::REG_ACC, 8'h6E);
		exec(exec_pkg::op_power_down);
		check({stop_q, wdc_q, psc_q}, 3'h7);
		check(flags, 5'h15);
		repeat (3) @(posedge clock);
		#1;
		check({op_ready, acc}, 9'h06E);
		@(posedge clock);
		wake <= 1'b1;
		@(posedge clock);
		wake <= 1'b0;
		exec(exec_pkg::op_watchdog_preclear_a);
		check(wdc_q, 1'b0);
		exec(exec_pkg::op_watchdog_preclear_a);
		check({wdc_q, 3'h0, flags}, 16'h0015);
		exec(exec_pkg::op_watchdog_preclear_b);
		check({wdc_q, 3'h0, flags}, 16'h0105);
		exec(exec_pkg::op_watchdog_preclear_a);
		check(wdc_q, 1'b0);
		exec(exec_pkg::op_watchdog_preclear_b);
		check(wdc_q, 1'b1);
		exec(exec_pkg::op_watchdog_preclear_a);
		exec(exec_pkg::op_nop);
		exec(exec_pkg::op_watchdog_preclear_b);
		check(wdc_q, 1'b0);
		stop_test();
	end
endmodule
